// File: hdl/conv_seq_pkg.sv
// package: register map, field layout and timing for the conversion sequencer
package conv_seq_pkg;

  // register byte offsets (one aligned word each)
  localparam logic [7:0] OFS_INPUT_SELECT = 8'h00;
  localparam logic [7:0] OFS_CTRL_A       = 8'h04;
  localparam logic [7:0] OFS_CTRL_B       = 8'h08;
  localparam logic [7:0] OFS_RESULT_LOW   = 8'h0C;
  localparam logic [7:0] OFS_RESULT_HIGH  = 8'h10;
  localparam logic [7:0] OFS_POWER        = 8'h14;

  // input_select_reg fields
  localparam int CHAN_LSB   = 0;
  localparam int CHAN_W     = 4;
  localparam int LEFT_ADJ_B = 5;
  localparam int REF_LSB    = 6;
  localparam int REF_W      = 2;

  // conv_ctrl_status_a fields
  localparam int PRESC_LSB  = 0;
  localparam int PRESC_W    = 3;
  localparam int FLAG_B     = 4;
  localparam int AUTO_B     = 5;
  localparam int START_B    = 6;
  localparam int ENABLE_B   = 7;

  // conv_ctrl_status_b and power register fields
  localparam int TSEL_LSB   = 0;
  localparam int TSEL_W     = 3;
  localparam int PWR_RED_B  = 0;

  // trigger_select code that means own completion flag (free running)
  localparam logic [2:0] TSEL_FREE_RUN = 3'h0;

  // reset values
  localparam logic [7:0] RST_INPUT_SELECT = 8'h00;
  localparam logic [7:0] RST_CTRL_A       = 8'h00;
  localparam logic [7:0] RST_CTRL_B       = 8'h00;
  localparam logic       RST_PWR_RED      = 1'b1;

  // conversion lengths in converter clock cycles
  localparam logic [4:0] CYC_NORMAL = 5'd13;
  localparam logic [4:0] CYC_FIRST  = 5'd25;
  localparam int         RES_W      = 10;

  // sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_CONV = 2'b10
  } seq_e;

  // analog side controls travel together
  typedef struct packed {
    logic       power_on;
    logic [3:0] channel;
    logic [1:0] reference;
    logic       sample;
  } analog_ctrl_s;

endpackage : conv_seq_pkg

// File: hdl/adc_conversion_sequencer.sv
// adc_conversion_sequencer: register file and control for a 10-bit SAR core
// Notes on behaviour
// - result 0 is ground, 3FF is reference minus step
// - channel field routes pins, ground or bandgap
// - selections reach converter only while enabled
// - right aligned default, left aligned when set
// - low read locks result bytes until high read
// - high byte read releases the result lock
// - completion flag sets even when result dropped
// - start bit begins conversion, clears when done
// - channel change waits for running conversion end
// - auto trigger enable uses selected trigger source
// - trigger rising edge resets prescaler, starts conversion
// - only rising edges start, not held levels
// - trigger edges during conversion are ignored
// - trigger source flags set regardless of masks
// - free running restarts regardless of own flag
// - software start still works with auto trigger
// - start bit reads one during any conversion
// - reference field picks supply or internal 1.1V
// - 13 converter cycles, first one takes 25
// - software start waits next converter clock edge
// - completion writes result, flag, clears start
// - prescaler runs when enabled, reset when not
//
// Design decisions made here: the register addresses and the APB slave port.
`timescale 1ns/100ps
module adc_conversion_sequencer
  import conv_seq_pkg::*;
(
  input  wire logic                CLK,
  input  wire logic                NRST,
  input  wire logic                PSEL,
  input  wire logic                PENABLE,
  input  wire logic                PWRITE,
  input  wire logic [7:0]          PADDR,
  input  wire logic [31:0]         PWDATA,
  output logic                     PREADY,
  output logic [31:0]              PRDATA,
  output logic                     PSLVERR,
  input  wire logic [7:0]          TRIGGER_SOURCES,
  input  wire logic [RES_W-1:0]    CORE_RESULT,
  output analog_ctrl_s             ANALOG_CTRL
);

  ////////////////////////////////////////////////////////////////////////////
  // registers and state
  logic [7:0]       input_select_r;
  logic [PRESC_W-1:0] presc_sel_r;
  logic             conv_enable_r;
  logic             auto_trig_r;
  logic             flag_r;
  logic [TSEL_W-1:0] tsel_r;
  logic             pwr_red_r;
  logic [RES_W-1:0] result_r;
  logic             lock_r;
  logic             first_r;
  logic [6:0]       presc_cnt_r;
  logic             trig_d_r;
  logic [4:0]       cyc_r;
  logic [4:0]       cyc_len_r;
  logic             done_r;
  seq_e             state_r;
  logic             trig_m_r;
  logic             trig_s_r;
  analog_ctrl_s     latched_r;

  logic wr_en;
  logic rd_en;
  logic start_wr;
  logic trig_edge;
  logic conv_tick;
  logic running;
  logic conv_done;
  logic trig_now;
  logic [15:0] res_view;

  // one-cycle access phase: ready is high in every access cycle
  assign wr_en = PSEL && PENABLE && PWRITE;
  assign rd_en = PSEL && PENABLE && !PWRITE;
  assign start_wr = wr_en && (PADDR == OFS_CTRL_A) && PWDATA[START_B]
                    && !pwr_red_r;
  assign running = (state_r != ST_IDLE);
  assign conv_done = (state_r == ST_CONV) && conv_tick
                     && (cyc_r == cyc_len_r - 5'd1);

  // prescaler ratio 2^(sel), at least 2; tick on terminal count
  function automatic logic [6:0] presc_top(input logic [PRESC_W-1:0] s);
    logic [7:0] r;
    r = 8'h01 << ((s == 3'h0) ? 3'h1 : s);
    presc_top = r[6:0] - 7'h01;
  endfunction : presc_top

  assign conv_tick = conv_enable_r && (presc_cnt_r == presc_top(presc_sel_r));

  ////////////////////////////////////////////////////////////////////////////
  // trigger synchroniser; first stage feeds only the second
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      trig_m_r <= 1'b0;
      trig_s_r <= 1'b0;
    end else begin
      trig_m_r <= TRIGGER_SOURCES[tsel_r];
      trig_s_r <= trig_m_r;
    end
  end

  // own flag as source means free running, else synchronised pin
  assign trig_now = (tsel_r == TSEL_FREE_RUN) ? flag_r : trig_s_r;

  // edge detect against last cycle's level
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      trig_d_r <= 1'b0;
    end else begin
      trig_d_r <= trig_now;
    end
  end

  // held level gives no edge; edges while busy are dropped
  assign trig_edge = conv_enable_r && auto_trig_r && !running
                     && (tsel_r != TSEL_FREE_RUN)
                     && trig_now && !trig_d_r;

  ////////////////////////////////////////////////////////////////////////////
  // converter clock prescaler
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      presc_cnt_r <= 7'h00;
    end else if (!conv_enable_r || trig_edge) begin
      presc_cnt_r <= 7'h00;
    end else if (conv_tick) begin
      presc_cnt_r <= 7'h00;
    end else begin
      presc_cnt_r <= presc_cnt_r + 7'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer: wait for converter edge, then count conversion cycles
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      state_r   <= ST_IDLE;
      cyc_r     <= 5'd0;
      cyc_len_r <= CYC_NORMAL;
      first_r   <= 1'b1;
      done_r    <= 1'b0;
    end else begin
      done_r <= conv_done;
      if (!conv_enable_r) begin
        state_r <= ST_IDLE;
        first_r <= 1'b1;
      end else begin
        case (state_r)
          ST_IDLE: begin
            cyc_r <= 5'd0;
            cyc_len_r <= first_r ? CYC_FIRST : CYC_NORMAL;
            if (trig_edge) begin
              state_r <= ST_CONV;
            end else if (start_wr) begin
              state_r <= ST_WAIT;
            end
          end
          ST_WAIT: begin
            if (conv_tick) begin
              state_r <= ST_CONV;
            end
          end
          ST_CONV: begin
            if (conv_tick) begin
              cyc_r <= cyc_r + 5'd1;
            end
            if (conv_done) begin
              first_r   <= 1'b0;
              cyc_r     <= 5'd0;
              cyc_len_r <= CYC_NORMAL;
              // free running restarts at once, flag state irrelevant
              if (auto_trig_r && tsel_r == TSEL_FREE_RUN) begin
                state_r <= ST_CONV;
              end else begin
                state_r <= ST_IDLE;
              end
            end
          end
          default: begin
            state_r <= ST_IDLE;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // analog controls: channel and reference tracked while idle, frozen during conversion; sample pulses in conversion cycle 1
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      latched_r <= '0;
    end else begin
      latched_r.power_on <= conv_enable_r;
      latched_r.sample   <= (state_r == ST_CONV) && (cyc_r == 5'd1);
      if (!conv_enable_r) begin
        latched_r.channel   <= 4'h0;
        latched_r.reference <= 2'h0;
      end else if (state_r != ST_CONV || conv_done) begin
        // 0-7 pins, E bandgap, F ground decoded by the core
        latched_r.channel <= input_select_r[CHAN_LSB +: CHAN_W];
        latched_r.reference <= input_select_r[REF_LSB +: REF_W];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control registers written over the bus
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      input_select_r <= RST_INPUT_SELECT;
      presc_sel_r    <= RST_CTRL_A[PRESC_LSB +: PRESC_W];
      conv_enable_r  <= RST_CTRL_A[ENABLE_B];
      auto_trig_r    <= RST_CTRL_A[AUTO_B];
      tsel_r         <= RST_CTRL_B[TSEL_LSB +: TSEL_W];
      pwr_red_r      <= RST_PWR_RED;
    end else if (wr_en) begin
      case (PADDR)
        OFS_INPUT_SELECT: input_select_r <= PWDATA[7:0];
        OFS_CTRL_A: begin
          presc_sel_r   <= PWDATA[PRESC_LSB +: PRESC_W];
          conv_enable_r <= PWDATA[ENABLE_B] && !pwr_red_r;
          auto_trig_r   <= PWDATA[AUTO_B];
        end
        OFS_CTRL_B: tsel_r <= PWDATA[TSEL_LSB +: TSEL_W];
        OFS_POWER: begin
          pwr_red_r <= PWDATA[PWR_RED_B];
        end
        default: ;
      endcase
    end else if (pwr_red_r) begin
      conv_enable_r <= 1'b0;
    end
  end

  // completion flag: set wins over write-one-to-clear
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      flag_r <= RST_CTRL_A[FLAG_B];
    end else if (conv_done) begin
      flag_r <= 1'b1;
    end else if (wr_en && PADDR == OFS_CTRL_A && PWDATA[FLAG_B]) begin
      flag_r <= 1'b0;
    end
  end

  // result capture and read-order lock
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      result_r <= '0;
      lock_r   <= 1'b0;
    end else begin
      if (conv_done && !lock_r) begin
        result_r <= CORE_RESULT;
      end
      if (rd_en && PADDR == OFS_RESULT_HIGH) begin
        lock_r <= 1'b0;
      end else if (rd_en && PADDR == OFS_RESULT_LOW) begin
        lock_r <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read mux, registered; answers in the access cycle's edge
  function automatic logic [15:0] aligned(input logic [RES_W-1:0] v,
                                          input logic left);
    aligned = left ? {v, 6'h00} : {6'h00, v};
  endfunction : aligned

  // both result bytes come from one aligned view of the held result
  assign res_view = aligned(result_r, input_select_r[LEFT_ADJ_B]);

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      PRDATA  <= 32'h0000_0000;
      PSLVERR <= 1'b0;
      PREADY  <= 1'b0;
    end else begin
      PREADY  <= PSEL && !PENABLE;
      PSLVERR <= 1'b0;
      PRDATA  <= 32'h0000_0000;
      if (PSEL && !PENABLE) begin
        case (PADDR)
          OFS_INPUT_SELECT: PRDATA <= {24'h00_0000, input_select_r};
          OFS_CTRL_A: PRDATA <= {24'h00_0000, conv_enable_r,
                                 running || start_wr, auto_trig_r, flag_r,
                                 1'b0, presc_sel_r};
          OFS_CTRL_B: PRDATA <= {29'h0000_0000, tsel_r};
          OFS_RESULT_LOW: PRDATA <= {24'h00_0000, res_view[7:0]};
          OFS_RESULT_HIGH: PRDATA <= {24'h00_0000, res_view[15:8]};
          OFS_POWER: PRDATA <= {31'h0000_0000, pwr_red_r};
          default: PSLVERR <= 1'b1;
        endcase
      end
    end
  end

  assign ANALOG_CTRL = latched_r;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_done;
    conv_done;
  endsequence
  sequence s_idle_after;
    ##1 (state_r == ST_IDLE);
  endsequence

  AST_LOCK_HOLDS: assert property (@(posedge CLK) disable iff (!NRST)
    (lock_r && conv_done) |=> $stable(result_r))
    else $error("result changed while locked");
  AST_HIGH_UNLOCK: assert property (@(posedge CLK) disable iff (!NRST)
    (rd_en && PADDR == OFS_RESULT_HIGH) |=> !lock_r)
    else $error("high read did not release lock");
  AST_FLAG_SET: assert property (@(posedge CLK) disable iff (!NRST)
    conv_done |=> flag_r)
    else $error("flag not set at completion");
  AST_SINGLE_END: assert property (@(posedge CLK) disable iff (!NRST)
    (s_done and !auto_trig_r) |-> s_idle_after)
    else $error("single conversion did not end");
  AST_FREE_RUN: assert property (@(posedge CLK) disable iff (!NRST)
    (conv_done && auto_trig_r && tsel_r == TSEL_FREE_RUN && conv_enable_r)
    |=> state_r == ST_CONV)
    else $error("free running did not restart");
  // an edge mid conversion must leave the prescaler counting on
  AST_BUSY_EDGE: assert property (@(posedge CLK) disable iff (!NRST)
    (state_r == ST_CONV && conv_enable_r && !conv_tick && trig_now
     && !trig_d_r) |=> presc_cnt_r == $past(presc_cnt_r) + 7'h01)
    else $error("edge accepted while busy");
  AST_PRESC_OFF: assert property (@(posedge CLK) disable iff (!NRST)
    !conv_enable_r |=> presc_cnt_r == 7'h00)
    else $error("prescaler ran while disabled");
  AST_CHAN_FROZEN: assert property (@(posedge CLK) disable iff (!NRST)
    (state_r == ST_CONV && $past(state_r) == ST_CONV && !$past(conv_done)
     && conv_enable_r && $past(conv_enable_r))
    |-> $stable(latched_r.channel))
    else $error("channel changed mid conversion");
  AST_LEN: assert property (@(posedge CLK) disable iff (!NRST)
    conv_done |-> (cyc_r == CYC_NORMAL - 5'd1 || cyc_r == CYC_FIRST - 5'd1))
    else $error("conversion length wrong");

  // accepted trigger edge: prescaler restarts and conversion begins
  AST_TRIG_START: assert property (@(posedge CLK) disable iff (!NRST)
    trig_edge |=> (state_r == ST_CONV && presc_cnt_r == 7'h00))
    else $error("trigger edge did not start conversion");

  // a software start holds in the wait state until a converter tick
  AST_SW_WAIT: assert property (@(posedge CLK) disable iff (!NRST)
    (state_r == ST_WAIT && conv_enable_r && !conv_tick) |=> state_r == ST_WAIT)
    else $error("software start ran ahead of converter clock");
  AST_SW_GO: assert property (@(posedge CLK) disable iff (!NRST)
    (state_r == ST_WAIT && conv_enable_r && conv_tick) |=> state_r == ST_CONV)
    else $error("software start missed converter clock");

  // disabled converter sees no selection and no power
  AST_OFF_IDLE: assert property (@(posedge CLK) disable iff (!NRST)
    !conv_enable_r |=> (state_r == ST_IDLE && latched_r.channel == 4'h0
                        && !latched_r.power_on))
    else $error("selection applied while disabled");

  // status read during any conversion shows the start bit set
  AST_BUSY_READ: assert property (@(posedge CLK) disable iff (!NRST)
    (PSEL && !PENABLE && PADDR == OFS_CTRL_A && running)
    |=> PRDATA[START_B])
    else $error("start bit read low while busy");

  // low byte read blocks later result updates
  AST_LOCK_SET: assert property (@(posedge CLK) disable iff (!NRST)
    (rd_en && PADDR == OFS_RESULT_LOW) |=> lock_r)
    else $error("low read did not lock result");

endmodule : adc_conversion_sequencer

// File: dv/sar_core_model.sv
// behavioural analog multiplexer and converter core facing the sequencer
`timescale 1ns/100ps
module sar_core_model
  import conv_seq_pkg::*;
(
  input  wire logic             CLK,
  input  wire logic             NRST,
  input  analog_ctrl_s          ANALOG_CTRL,
  output logic [RES_W-1:0]      CORE_RESULT
);
  logic [RES_W-1:0] held_r;

  ////////////////////////////////////////////////////////////////////////////
  // code carries channel and reference so misrouting shows in the result
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      held_r <= 10'h000;
    end else if (ANALOG_CTRL.power_on && ANALOG_CTRL.sample) begin
      held_r <= {ANALOG_CTRL.channel,
                 ANALOG_CTRL.reference, 4'h5};
    end else if (!ANALOG_CTRL.power_on) begin
      held_r <= ~held_r; // unpowered core holds no stable code
    end
  end

  assign CORE_RESULT = held_r;
endmodule : sar_core_model

// File: dv/adc_conversion_sequencer_test.sv
// testbench: register-level tests of the conversion sequencer
`timescale 1ns/100ps
module adc_conversion_sequencer_test
  import conv_seq_pkg::*;
;
  logic             CLK, NRST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, e;
  logic [7:0]       PADDR, TRIGGER_SOURCES;
  logic [31:0]      PWDATA, PRDATA, d;
  logic [RES_W-1:0] CORE_RESULT, r;
  analog_ctrl_s     ANALOG_CTRL;
  int               miscompares = 0;
  int               checks_done = 0;

  adc_conversion_sequencer adc_conversion_sequencer_i (.CLK(CLK),
    .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY), .PRDATA(PRDATA),
    .PSLVERR(PSLVERR), .TRIGGER_SOURCES(TRIGGER_SOURCES),
    .CORE_RESULT(CORE_RESULT), .ANALOG_CTRL(ANALOG_CTRL));
  sar_core_model sar_core_model_i (.CLK(CLK), .NRST(NRST),
    .ANALOG_CTRL(ANALOG_CTRL), .CORE_RESULT(CORE_RESULT));

  ////////////////////////////////////////////////////////////////////////////
  // 50 ns clock
  initial begin
    CLK = 1'b0;
    forever #25 CLK = ~CLK;
  end

  // expected core code for a channel, reference field fixed at 1
  function automatic logic [9:0] res(input logic [3:0] c);
    return {c, 2'b01, 4'h5};
  endfunction : res

  function automatic logic [31:0] sel(input logic [3:0] c, input logic l);
    return {24'h000000, 2'b01, l, 1'b0, c};
  endfunction : sel

  task automatic chk(input string n, input logic [31:0] x,
                     input logic [31:0] g);
    checks_done++;
    if (g !== x) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", n, x, g);
    end
  endtask : chk

  // one apb transfer; held until, and data taken at, the edge with pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rdo, output logic err);
    int n;
    n = 0;
    @(posedge CLK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= wd;
    @(posedge CLK);
    PENABLE <= 1'b1;
    // values read here are those standing just before this edge
    @(posedge CLK);
    while (PREADY !== 1'b1 && n < 16) begin
      @(posedge CLK);
      n++;
    end
    chk("pready", 32'h1, 32'(PREADY));
    rdo = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic [31:0] t;
    logic        x;
    apb(1'b1, a, v, t, x);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    logic x;
    apb(1'b0, a, 32'h0, v, x);
  endtask : rd

  // poll a status bit; bounded so a stuck design cannot hang the run
  task automatic wait_bit(input int b, input logic v);
    logic [31:0] t;
    int          n;
    n = 0;
    rd(OFS_CTRL_A, t);
    while (t[b] !== v && n < 300) begin
      rd(OFS_CTRL_A, t);
      n++;
    end
    chk("status bit", 32'(v), 32'(t[b]));
  endtask : wait_bit

  task automatic test_done;
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : test_done

  // watchdog, roughly fifty times the expected run length
  initial begin
    repeat (30000) @(posedge CLK);
    miscompares++;
    test_done();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    PSEL = 1'b0; PENABLE = 1'b0; PWRITE = 1'b0; PADDR = 8'h00;
    PWDATA = 32'h0; TRIGGER_SOURCES = 8'h00; NRST = 1'b0;
    repeat (10) @(posedge CLK);
    NRST <= 1'b1;
    rd(OFS_CTRL_A, d); chk("ctrl_a", {24'h0, RST_CTRL_A}, d);
    rd(OFS_INPUT_SELECT, d); chk("isel", {24'h0, RST_INPUT_SELECT}, d);
    rd(OFS_CTRL_B, d); chk("ctrl_b", {24'h0, RST_CTRL_B}, d);
    rd(OFS_POWER, d); chk("power", {31'h0, RST_PWR_RED}, d);
    apb(1'b0, 8'h18, 32'h0, d, e); chk("slverr", 32'h1, 32'(e));
    wr(OFS_CTRL_A, 32'h80);
    rd(OFS_CTRL_A, d); chk("enable refused", 32'h0, d);
    wr(OFS_INPUT_SELECT, sel(4'h3, 1'b0));
    repeat (2) @(posedge CLK);
    chk("chan off", 32'h0, 32'(ANALOG_CTRL.channel));
    wr(OFS_POWER, 32'h0);
    wr(OFS_CTRL_A, 32'h80);
    $display("test reset_power done");
    // single conversion, right aligned
    wr(OFS_INPUT_SELECT, sel(4'h3, 1'b0));
    wr(OFS_CTRL_A, 32'hC0);
    rd(OFS_CTRL_A, d); chk("busy", 32'h1, 32'(d[START_B]));
    wait_bit(START_B, 1'b0);
    rd(OFS_CTRL_A, d); chk("flag", 32'h1, 32'(d[FLAG_B]));
    r = res(4'h3);
    rd(OFS_RESULT_LOW, d); chk("low", {24'h0, r[7:0]}, d);
    rd(OFS_RESULT_HIGH, d); chk("high", {30'h0, r[9:8]}, d);
    $display("test single done");
    // low read locks; a result completing meanwhile is lost
    wr(OFS_CTRL_A, 32'h90);
    rd(OFS_RESULT_LOW, d);
    wr(OFS_INPUT_SELECT, sel(4'h5, 1'b0));
    wr(OFS_CTRL_A, 32'hC0);
    wait_bit(START_B, 1'b0);
    rd(OFS_CTRL_A, d); chk("flag", 32'h1, 32'(d[FLAG_B]));
    rd(OFS_RESULT_HIGH, d); chk("high", {30'h0, r[9:8]}, d);
    wr(OFS_CTRL_A, 32'hC0);
    wait_bit(START_B, 1'b0);
    r = res(4'h5);
    rd(OFS_RESULT_LOW, d); chk("low", {24'h0, r[7:0]}, d);
    rd(OFS_RESULT_HIGH, d); chk("high", {30'h0, r[9:8]}, d);
    $display("test lock done");
    // channel change mid conversion, then left aligned on new channel
    wr(OFS_INPUT_SELECT, sel(4'h1, 1'b0));
    wr(OFS_CTRL_A, 32'hC0);
    wr(OFS_INPUT_SELECT, sel(4'h2, 1'b0));
    wait_bit(START_B, 1'b0);
    r = res(4'h1);
    rd(OFS_RESULT_LOW, d); chk("low", {24'h0, r[7:0]}, d);
    rd(OFS_RESULT_HIGH, d);
    wr(OFS_INPUT_SELECT, sel(4'h2, 1'b1));
    wr(OFS_CTRL_A, 32'hC0);
    wait_bit(START_B, 1'b0);
    r = res(4'h2);
    rd(OFS_RESULT_HIGH, d); chk("high", {24'h0, r[9:2]}, d);
    rd(OFS_RESULT_LOW, d); chk("low", {24'h0, r[1:0], 6'h0}, d);
    $display("test channel_align done");
    // edge trigger on source 1; held level and mid edge start nothing
    wr(OFS_CTRL_B, 32'h1);
    wr(OFS_CTRL_A, 32'hB0);
    TRIGGER_SOURCES <= 8'h02;
    repeat (6) @(posedge CLK);
    rd(OFS_CTRL_A, d); chk("busy", 32'h1, 32'(d[START_B]));
    TRIGGER_SOURCES <= 8'h00;
    repeat (2) @(posedge CLK);
    TRIGGER_SOURCES <= 8'h02;
    wait_bit(START_B, 1'b0);
    wr(OFS_CTRL_A, 32'hB0);
    repeat (100) @(posedge CLK);
    rd(OFS_CTRL_A, d); chk("flag", 32'h0, 32'(d[FLAG_B]));
    TRIGGER_SOURCES <= 8'h00;
    repeat (4) @(posedge CLK);
    TRIGGER_SOURCES <= 8'h02;
    wait_bit(FLAG_B, 1'b1);
    wait_bit(START_B, 1'b0);
    wr(OFS_CTRL_A, 32'hF0);
    wait_bit(FLAG_B, 1'b1);
    wait_bit(START_B, 1'b0);
    $display("test trigger done");
    // free running from the own completion flag
    wr(OFS_CTRL_B, {29'h0, TSEL_FREE_RUN});
    wr(OFS_CTRL_A, 32'hF0);
    wait_bit(FLAG_B, 1'b1);
    rd(OFS_CTRL_A, d); chk("busy", 32'h1, 32'(d[START_B]));
    wr(OFS_CTRL_A, 32'hB0);
    wait_bit(FLAG_B, 1'b1);
    wr(OFS_CTRL_A, 32'h80);
    wait_bit(START_B, 1'b0);
    $display("test free_run done");
    test_done();
  end
endmodule : adc_conversion_sequencer_test
